// file: logic/obcd_decoder.sv
// option byte store, apb access port and static configuration decoder.
// assumes i_por pulses once at power-up; i_rst is the system reset and
// the erase handshake partner raises i_mem_erase_done when done.
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/10ps

module obcd_decoder (
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic              i_por,
    input  wire logic              i_prog_mode,
    input  wire obcd_pkg::obcd_apb_req_t i_apb,
    output obcd_pkg::obcd_apb_rsp_t      o_apb,
    output obcd_pkg::obcd_cfg_t          o_cfg,
    output logic                   o_cfg_valid,
    output logic                   o_mem_erase,
    input  wire logic              i_mem_erase_done
);
    import obcd_pkg::*;

    function automatic obcd_cfg_t decode_cfg(input logic [7:0] b0,
                                             input logic [7:0] b1);
        obcd_cfg_t c;
        c.resonator_drive_range =
            obcd_range_t'(b0[B0_RANGE_MSB:B0_RANGE_LSB]);
        c.external_clock_input =
            (c.resonator_drive_range == RANGE_EXT_RES_IN) ||
            (c.resonator_drive_range == RANGE_EXT_ALT);
        c.alternate_clock_pin =
            (c.resonator_drive_range == RANGE_EXT_ALT);
        c.rc_osc_enable        = ~b1[B1_RC_OFF];
        // rc start-up uses the long delay only with the all-ones range
        c.startup_long = c.rc_osc_enable &&
            (c.resonator_drive_range == RANGE_EXT_ALT);
        c.boot_sector_size =
            obcd_sector_t'(b0[B0_SEC_MSB:B0_SEC_LSB]);
        c.readout_protect       = b0[B0_RDP];
        c.flash_write_lock      = b0[B0_WRP];
        c.pll_factor_select     = b1[B1_PLL_FACT];
        c.main_pll_bypass       = b1[B1_PLL_OFF];
        c.timer_fast_pll_bypass = b1[B1_PLL32_OFF];
        c.supply_drop_threshold =
            obcd_lvd_t'(b1[B1_LVD_MSB:B1_LVD_LSB]);
        c.supply_drop_enable =
            (c.supply_drop_threshold != LVD_OFF);
        c.watchdog_software_mode = b1[B1_WATCHDOG_SOFTWARE_MODE];
        c.watchdog_halt_reset    = b1[B1_WATCHDOG_HALT_RESET];
        return c;
    endfunction : decode_cfg

    localparam obcd_cfg_t CFG_RESET = decode_cfg(ERASED_BYTE, ERASED_BYTE);

    logic [7:0]  opt0_q;
    logic [7:0]  opt1_q;
    obcd_cfg_t   cfg_q;
    logic        load_q;
    logic        valid_q;
    obcd_state_t state_q;
    logic        pready_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    logic        access;
    logic        is_opt;
    logic        mapped;
    logic        locked;
    logic        busy;
    logic        fault;
    logic        wr_ok;
    logic        erase_go;

    assign access = i_apb.psel && i_apb.penable;
    assign is_opt = (i_apb.paddr == OFF_OPT0) || (i_apb.paddr == OFF_OPT1);
    assign mapped = is_opt || (i_apb.paddr == OFF_CTRL) ||
                    (i_apb.paddr == OFF_STAT);
    assign locked = opt0_q[B0_WRP];
    assign busy   = (state_q != ST_IDLE);
    // option bytes are invisible to application code
    assign fault  = !mapped ||
                    (is_opt && !i_prog_mode) ||
                    (i_apb.pwrite && (i_apb.paddr != OFF_STAT) &&
                     (!i_prog_mode || locked || busy));
    assign wr_ok  = access && pready_q && i_apb.pwrite && !fault;
    assign erase_go = wr_ok && (i_apb.paddr == OFF_CTRL) &&
                      i_apb.pwdata[CTRL_ERASE];

    // one wait state so read data can come from a flop
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (access && !pready_q) begin
            pready_q  <= 1'b1;
            pslverr_q <= fault;
            prdata_q  <= 32'h0000_0000;
            if (!fault && !i_apb.pwrite) begin
                unique case (i_apb.paddr)
                    OFF_OPT0: prdata_q[7:0] <= opt0_q;
                    OFF_OPT1: prdata_q[7:0] <= opt1_q;
                    OFF_CTRL: prdata_q[CTRL_ERASE] <= busy;
                    default: begin
                        prdata_q[$bits(obcd_cfg_t)-1:0] <= cfg_q;
                        prdata_q[STAT_PROG_MODE] <= i_prog_mode;
                        prdata_q[STAT_BUSY] <= busy;
                    end
                endcase
            end
        end else begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    assign o_apb.pready  = pready_q;
    assign o_apb.prdata  = prdata_q;
    assign o_apb.pslverr = pslverr_q && pready_q;

    // non-volatile model: only power-up restores the shipped content
    always_ff @(posedge i_clk) begin
        if (i_por) begin
            opt0_q <= OPT0_DEFAULT;
            opt1_q <= OPT1_DEFAULT;
        end else if (state_q == ST_OPT_ERASE) begin
            opt0_q <= ERASED_BYTE;
            opt1_q <= ERASED_BYTE;
        end else if (wr_ok && (i_apb.paddr == OFF_OPT0)) begin
            // bit 7 is stored as written; keeping it one is up to the tool
            opt0_q <= i_apb.pwdata[7:0];
        end else if (wr_ok && (i_apb.paddr == OFF_OPT1)) begin
            opt1_q <= i_apb.pwdata[7:0];
        end
    end

    // protected parts wipe program memory before the bytes are erased
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (erase_go && opt0_q[B0_RDP]) begin
                        state_q <= ST_MEM_ERASE;
                    end else if (erase_go) begin
                        state_q <= ST_OPT_ERASE;
                    end
                end
                ST_MEM_ERASE: begin
                    if (i_mem_erase_done) begin
                        state_q <= ST_OPT_ERASE;
                    end
                end
                ST_OPT_ERASE: state_q <= ST_IDLE;
                default:      state_q <= ST_IDLE;
            endcase
        end
    end

    assign o_mem_erase = (state_q == ST_MEM_ERASE);

    // settings sampled in the first cycle after reset release, then frozen
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            load_q  <= 1'b1;
            valid_q <= 1'b0;
            cfg_q   <= CFG_RESET;
        end else if (load_q) begin
            load_q  <= 1'b0;
            valid_q <= 1'b1;
            cfg_q   <= decode_cfg(opt0_q, opt1_q);
        end
    end

    assign o_cfg       = cfg_q;
    assign o_cfg_valid = valid_q;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    chk_app_no_change: assert property (
        (!i_prog_mode && !i_por && state_q == ST_IDLE)
        |=> ($stable(opt0_q) && $stable(opt1_q)))
        else $error("option bytes changed outside programming mode");
    chk_range_latch: assert property (
        load_q |=> (o_cfg.resonator_drive_range ==
                    $past(opt0_q[B0_RANGE_MSB:B0_RANGE_LSB])))
        else $error("range field not latched from byte 0");
    chk_ext_clock_sel: assert property (
        o_cfg_valid |-> (o_cfg.external_clock_input ==
            (o_cfg.resonator_drive_range[0] &&
             o_cfg.resonator_drive_range[2]) &&
            o_cfg.alternate_clock_pin ==
            (o_cfg.resonator_drive_range == RANGE_EXT_ALT)))
        else $error("external clock source decode wrong");
    chk_sector_latch: assert property (
        load_q |=> (o_cfg.boot_sector_size ==
                    $past(opt0_q[B0_SEC_MSB:B0_SEC_LSB])))
        else $error("sector size not latched");
    chk_protect_bits: assert property (
        load_q |=> (o_cfg.readout_protect == $past(opt0_q[B0_RDP]) &&
                    o_cfg.flash_write_lock == $past(opt0_q[B0_WRP])))
        else $error("protection bits not latched");
    chk_rdp_mem_first: assert property (
        (erase_go && opt0_q[B0_RDP])
        |=> o_mem_erase && opt0_q == $past(opt0_q))
        else $error("protected erase did not wipe memory first");
    chk_opt_after_mem: assert property (
        (o_mem_erase && i_mem_erase_done && !i_por)
        |=> ##1 (opt0_q == ERASED_BYTE && opt1_q == ERASED_BYTE))
        else $error("bytes not erased after memory wipe");
    chk_write_lock: assert property (
        (locked && !i_por && state_q == ST_IDLE)
        |=> ($stable(opt0_q) && $stable(opt1_q) && !o_mem_erase))
        else $error("locked option bytes were modified");
    chk_pll_latch: assert property (
        load_q |=> (o_cfg.pll_factor_select == $past(opt1_q[B1_PLL_FACT])
            && o_cfg.main_pll_bypass == $past(opt1_q[B1_PLL_OFF])
            && o_cfg.timer_fast_pll_bypass == $past(opt1_q[B1_PLL32_OFF])))
        else $error("pll fields not latched");
    chk_rc_osc: assert property (
        load_q |=> (o_cfg.rc_osc_enable == !$past(opt1_q[B1_RC_OFF])))
        else $error("rc oscillator enable inverted wrong");
    chk_lvd_enable: assert property (
        o_cfg_valid |-> (o_cfg.supply_drop_enable ==
                         (o_cfg.supply_drop_threshold != LVD_OFF)))
        else $error("supply drop enable disagrees with threshold");
    chk_wdg_latch: assert property (
        load_q |=> (o_cfg.watchdog_software_mode == $past(opt1_q[B1_WATCHDOG_SOFTWARE_MODE])
            && o_cfg.watchdog_halt_reset == $past(opt1_q[B1_WATCHDOG_HALT_RESET])))
        else $error("watchdog fields not latched");
    chk_cfg_hold: assert property (
        (o_cfg_valid && !load_q) |=> ($stable(o_cfg) && o_cfg_valid))
        else $error("settings changed between resets");

    cov_opt0_write: cover property (wr_ok && i_apb.paddr == OFF_OPT0);
    cov_rdp_erase: cover property (o_mem_erase ##[1:20] !o_mem_erase);
    cov_plain_erase: cover property (erase_go && !opt0_q[B0_RDP]);
    cov_load: cover property (load_q ##1 o_cfg_valid);

endmodule : obcd_decoder

// file: logic/obcd_pkg.sv
// package for the option byte configuration decoder: register map,
// option byte field layout, decoded setting types and apb carriers.
// assumes a 32-bit apb with byte addresses in the low eight bits.
package obcd_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_OPT0 = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_OPT1 = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_STAT = 8'h0C;

    // erased content of a byte, all ones
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // factory content of the option bytes at power-up
    localparam logic [7:0] OPT0_DEFAULT = 8'hFC;
    localparam logic [7:0] OPT1_DEFAULT = 8'hEF;

    // option byte 0 fields
    localparam int unsigned B0_RSV       = 7;
    localparam int unsigned B0_RANGE_MSB = 6;
    localparam int unsigned B0_RANGE_LSB = 4;
    localparam int unsigned B0_SEC_MSB   = 3;
    localparam int unsigned B0_SEC_LSB   = 2;
    localparam int unsigned B0_RDP       = 1;
    localparam int unsigned B0_WRP       = 0;

    // option byte 1 fields
    localparam int unsigned B1_PLL_FACT  = 7;
    localparam int unsigned B1_PLL_OFF   = 6;
    localparam int unsigned B1_PLL32_OFF = 5;
    localparam int unsigned B1_RC_OFF    = 4;
    localparam int unsigned B1_LVD_MSB   = 3;
    localparam int unsigned B1_LVD_LSB   = 2;
    localparam int unsigned B1_WATCHDOG_SOFTWARE_MODE    = 1;
    localparam int unsigned B1_WATCHDOG_HALT_RESET  = 0;

    // control and status bits
    localparam int unsigned CTRL_ERASE     = 0;
    localparam int unsigned STAT_PROG_MODE = 24;
    localparam int unsigned STAT_BUSY      = 25;

    typedef enum logic [2:0] {
        RANGE_LOWEST     = 3'b000,
        RANGE_LOWER_MID  = 3'b001,
        RANGE_UPPER_MID  = 3'b010,
        RANGE_HIGH_SPEED = 3'b011,
        RANGE_WATCH_XTAL = 3'b100,
        RANGE_EXT_RES_IN = 3'b101,
        RANGE_RESERVED   = 3'b110,
        RANGE_EXT_ALT    = 3'b111
    } obcd_range_t;

    typedef enum logic [1:0] {
        SEC_HALF_K = 2'b00,
        SEC_1K     = 2'b01,
        SEC_2K     = 2'b10,
        SEC_4K     = 2'b11
    } obcd_sector_t;

    typedef enum logic [1:0] {
        LVD_LOWEST  = 2'b00,
        LVD_MEDIUM  = 2'b01,
        LVD_HIGHEST = 2'b10,
        LVD_OFF     = 2'b11
    } obcd_lvd_t;

    typedef enum logic [1:0] {
        ST_IDLE      = 2'b00,
        ST_MEM_ERASE = 2'b01,
        ST_OPT_ERASE = 2'b10
    } obcd_state_t;

    typedef struct packed {
        obcd_range_t  resonator_drive_range;
        logic         external_clock_input;
        logic         alternate_clock_pin;
        logic         startup_long;
        obcd_sector_t boot_sector_size;
        logic         readout_protect;
        logic         flash_write_lock;
        logic         pll_factor_select;
        logic         main_pll_bypass;
        logic         timer_fast_pll_bypass;
        logic         rc_osc_enable;
        logic         supply_drop_enable;
        obcd_lvd_t    supply_drop_threshold;
        logic         watchdog_software_mode;
        logic         watchdog_halt_reset;
    } obcd_cfg_t;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } obcd_apb_req_t;

    typedef struct packed {
        logic              pready;
        logic [DATA_W-1:0] prdata;
        logic              pslverr;
    } obcd_apb_rsp_t;

endpackage : obcd_pkg

// file: verif/obcd_prog_model.sv
// programming tool model: apb master transfers and flash erase answer.
// assumes the decoder answers each transfer with a single pready pulse.
`timescale 1ns/10ps
module obcd_prog_model #(
    parameter int ERASE_DLY = 4
) (
    input  wire logic                    i_clk,
    output obcd_pkg::obcd_apb_req_t      o_apb,
    input  wire obcd_pkg::obcd_apb_rsp_t i_apb,
    input  wire logic                    i_mem_erase,
    output logic                         o_mem_erase_done
);
    import obcd_pkg::*;
    logic [7:0] erase_cnt_q = 8'h00;

    initial o_apb = '0;

    // memory answers a whole-array erase after a short wait
    always @(posedge i_clk) begin
        erase_cnt_q <= i_mem_erase ? erase_cnt_q + 8'h01 : 8'h00;
    end
    assign o_mem_erase_done = i_mem_erase && erase_cnt_q == 8'(ERASE_DLY);

    // pready, read data and error are taken at the rising edge at which
    // pready is sampled high; released lines show inverted values
    task automatic xfer(input logic wr, input logic [7:0] addr,
                        input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err);
        int n;
        n = 0;
        @(posedge i_clk);
        o_apb <= '{1'b1, 1'b0, wr, addr, wdata};
        @(posedge i_clk);
        o_apb.penable <= 1'b1;
        @(posedge i_clk);
        while (i_apb.pready !== 1'b1 && n < 20) begin
            @(posedge i_clk);
            n++;
        end
        rdata = i_apb.prdata;
        err = (n < 20) ? i_apb.pslverr : 1'bx;
        o_apb <= '{1'b0, 1'b0, ~wr, ~addr, ~wdata};
    endtask : xfer
endmodule : obcd_prog_model

// file: verif/tb.sv
// self-checking bench for the option byte decoder.
// assumes the programming tool model is the only apb master.
`timescale 1ns/10ps
module tb;
    import obcd_pkg::*;
    logic          i_clk = 1'b0;
    logic          i_rst = 1'b1;
    logic          i_por = 1'b1;
    logic          i_prog_mode = 1'b0;
    obcd_apb_req_t apb_req;
    obcd_apb_rsp_t apb_rsp;
    obcd_cfg_t     cfg;
    obcd_cfg_t     cfg_ff;
    obcd_cfg_t     cfg_exp;
    logic          cfg_valid;
    logic          mem_erase;
    logic          erase_done;
    int            mismatches = 0;
    int            tests_run = 0;

    always #20 i_clk = ~i_clk;

    obcd_decoder obcd_decoder_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_por(i_por),
        .i_prog_mode(i_prog_mode), .i_apb(apb_req), .o_apb(apb_rsp),
        .o_cfg(cfg), .o_cfg_valid(cfg_valid), .o_mem_erase(mem_erase),
        .i_mem_erase_done(erase_done));

    obcd_prog_model obcd_prog_model_inst (
        .i_clk(i_clk), .o_apb(apb_req), .i_apb(apb_rsp),
        .i_mem_erase(mem_erase), .o_mem_erase_done(erase_done));

    function automatic obcd_cfg_t exp_cfg(input logic [7:0] b0,
                                          input logic [7:0] b1);
        obcd_cfg_t c;
        c.resonator_drive_range  = obcd_range_t'(b0[6:4]);
        c.external_clock_input   = b0[6:4] inside {3'b101, 3'b111};
        c.alternate_clock_pin    = b0[6:4] == 3'b111;
        c.startup_long           = !b1[4] && b0[6:4] == 3'b111;
        c.boot_sector_size       = obcd_sector_t'(b0[3:2]);
        c.readout_protect        = b0[1];
        c.flash_write_lock       = b0[0];
        c.pll_factor_select      = b1[7];
        c.main_pll_bypass        = b1[6];
        c.timer_fast_pll_bypass  = b1[5];
        c.rc_osc_enable          = !b1[4];
        c.supply_drop_enable     = b1[3:2] != 2'b11;
        c.supply_drop_threshold  = obcd_lvd_t'(b1[3:2]);
        c.watchdog_software_mode = b1[1];
        c.watchdog_halt_reset    = b1[0];
        return c;
    endfunction : exp_cfg

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    // one apb transfer, then the error flag and, for reads only, the read data are judged
    task automatic bus(input string what, input logic wr,
                       input logic [7:0] addr, input logic [31:0] wdata,
                       input logic [31:0] exp_rd, input logic exp_err);
        logic [31:0] rd;
        logic        err;
        obcd_prog_model_inst.xfer(wr, addr, wdata, rd, err);
        check({what, " err"}, {31'h0, exp_err}, {31'h0, err});
        if (!wr) begin
            check({what, " data"}, exp_rd, rd);
        end
    endtask : bus

    task automatic set_prog(input logic pm);
        @(posedge i_clk);
        i_prog_mode <= pm;
    endtask : set_prog

    // erased store decodes while reset holds; valid only after release
    task automatic s_reset;
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (3) @(posedge i_clk);
        #1;
        check("cfg in reset", 32'(cfg_ff), 32'(cfg));
        check("valid in reset", 32'h0000_0000, 32'(cfg_valid));
        @(posedge i_clk);
        i_por <= 1'b0;
        i_rst <= 1'b0;
        repeat (3) @(posedge i_clk);
        #1;
        check("cfg", 32'(cfg_exp), 32'(cfg));
        check("valid", 32'h0000_0001, 32'(cfg_valid));
    endtask : s_reset

    task automatic s_opt_access;
        set_prog(1'b1);
        bus("opt0 rd", 1'b0, OFF_OPT0, 32'h0, 32'h0000_00FC, 1'b0);
        bus("opt1 rd", 1'b0, OFF_OPT1, 32'h0, 32'h0000_00EF, 1'b0);
        set_prog(1'b0);
        bus("opt0 np", 1'b0, OFF_OPT0, 32'h0, 32'h0000_0000, 1'b1);
        bus("opt1 np", 1'b1, OFF_OPT1, 32'h0, 32'h0, 1'b1);
    endtask : s_opt_access

    // new bytes only count after reset; a protected erase wipes memory
    task automatic s_program;
        set_prog(1'b1);
        bus("opt1 wr", 1'b1, OFF_OPT1, 32'h0000_005A, 32'h0, 1'b0);
        bus("opt0 wr", 1'b1, OFF_OPT0, 32'h0000_00B6, 32'h0, 1'b0);
        bus("opt0 bk", 1'b0, OFF_OPT0, 32'h0, 32'h0000_00B6, 1'b0);
        check("cfg early", 32'(cfg_exp), 32'(cfg));
        cfg_exp = exp_cfg(8'hB6, 8'h5A);
        s_reset();
        bus("erase", 1'b1, OFF_CTRL, 32'h0000_0001, 32'h0, 1'b0);
        @(posedge i_clk);
        #1;
        check("mem wipe", 32'h0000_0001, 32'(mem_erase));
        bus("opt0 mid", 1'b0, OFF_OPT0, 32'h0, 32'h0000_00B6, 1'b0);
        repeat (8) @(posedge i_clk);
        bus("opt0 ers", 1'b0, OFF_OPT0, 32'h0, 32'h0000_00FF, 1'b0);
        check("wipe end", 32'h0000_0000, 32'(mem_erase));
    endtask : s_program

    // erased parts carry the lock bit, so every change must be refused
    task automatic s_locked;
        set_prog(1'b1);
        bus("opt0 wr", 1'b1, OFF_OPT0, 32'h0000_00FC, 32'h0, 1'b1);
        bus("opt1 wr", 1'b1, OFF_OPT1, 32'h0000_00EF, 32'h0, 1'b1);
        bus("erase", 1'b1, OFF_CTRL, 32'h0000_0001, 32'h0, 1'b1);
        repeat (4) @(posedge i_clk);
        #1;
        check("mem erase", 32'h0000_0000, 32'(mem_erase));
        bus("opt0 kept", 1'b0, OFF_OPT0, 32'h0, 32'h0000_00FF, 1'b0);
        bus("stat wr", 1'b1, OFF_STAT, 32'hFFFF_FFFF, 32'h0, 1'b0);
        bus("unmapped", 1'b0, 8'h10, 32'h0, 32'h0000_0000, 1'b1);
        bus("unmap wr", 1'b1, 8'h40, 32'h0000_0001, 32'h0, 1'b1);
    endtask : s_locked

    task automatic s_status;
        bus("stat pm", 1'b0, OFF_STAT, 32'h0,
            {7'h00, 1'b1, 5'h00, 19'(cfg_exp)}, 1'b0);
        set_prog(1'b0);
        bus("stat np", 1'b0, OFF_STAT, 32'h0,
            {7'h00, 1'b0, 5'h00, 19'(cfg_exp)}, 1'b0);
        check("cfg held", 32'(cfg_exp), 32'(cfg));
    endtask : s_status

    initial begin
        cfg_ff = exp_cfg(8'hFF, 8'hFF);
        cfg_exp = exp_cfg(8'hFC, 8'hEF);
        s_reset();
        s_opt_access();
        s_program();
        s_locked();
        s_status();
        cfg_exp = cfg_ff;
        s_reset();
        report_and_stop();
    end

    initial begin
        #(40 * 3000);
        mismatches++;
        report_and_stop();
    end
endmodule : tb
